// ---- pkg/stc_pkg.sv ----
package stc_pkg;
	localparam int unsigned AW = 10;
	localparam int unsigned DW = 24;
	localparam int unsigned TW = 17;
	localparam logic [9:0] ADDR_EN = 10'h2B0;
	localparam logic [9:0] ADDR_CFG = 10'h2B1;
	localparam logic [9:0] ADDR_RES = 10'h2B2;
	localparam logic [9:0] ADDR_TAD = 10'h2B5;
	localparam logic [9:0] ADDR_IST = 10'h2B6;
	localparam logic [9:0] ADDR_IMSK = 10'h2B7;
	localparam logic [7:0] CFG_RST = 8'h05;
	localparam int unsigned AVG_LSB = 2;
	localparam int unsigned ACC_LSB = 0;
	localparam int unsigned DONE_BIT = 17;
	localparam int unsigned INV_BIT = 16;
	localparam int unsigned COARSE_LSB = 8;
	localparam int unsigned FINE_LSB = 0;
	localparam int unsigned IRQ_DONE = 0;
	localparam int unsigned IRQ_FAIL = 1;
	localparam int unsigned CAL_SCALE = 384 * 19;
	localparam logic [8:0] FRAC_HALF = 9'h080;

	typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_ACC, ST_FIN, ST_DONE, ST_FAIL} stc_state_t;

	// cycles per accumulation or number of averages for a two-bit code
	function automatic logic [8:0] len_of(input logic [1:0] code);
		return 9'h004 << {code, 1'b0};
	endfunction

	// longest sysref period that an accumulation code supports
	function automatic logic [15:0] per_max(input logic [1:0] code);
		case (code)
			2'h0: return 16'h0080;
			2'h1: return 16'h0680;
			2'h2: return 16'h1E80;
			default: return 16'h7E80;
		endcase
	endfunction

	// exponent 2*(avg+acc+2) of the full measurement length
	function automatic logic [4:0] shift_of(input logic [1:0] a, input logic [1:0] h);
		return ({3'h0, a} + {3'h0, h} + 5'h02) << 1;
	endfunction
endpackage

// ---- core/stc_accum.sv ----
module stc_accum (
	// clock and reset
	input  logic       clk,
	input  logic       nrst,
	// control
	input  logic       start,
	input  logic [1:0] len_code,
	input  logic       level,
	// result
	output logic       done,
	output logic [8:0] count
);
	logic       busy_reg;
	logic [8:0] left_reg;
	logic [8:0] sum_reg;
	logic       done_reg;
	logic [8:0] count_reg;

	//////////////////////////////////////////////////////////////////////////
	// high-level cycles over one accumulation window
	always_ff @(posedge clk) begin
		if (!nrst) begin
			busy_reg <= 1'b0;
			left_reg <= 9'h000;
			sum_reg <= 9'h000;
		end else if (start) begin
			busy_reg <= 1'b1;
			left_reg <= stc_pkg::len_of(len_code) - 9'h001;
			sum_reg <= 9'h000;
		end else if (busy_reg) begin
			sum_reg <= sum_reg + {8'h00, level};
			left_reg <= left_reg - 9'h001;
			if (left_reg == 9'h000) begin
				busy_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			done_reg <= 1'b0;
			count_reg <= 9'h000;
		end else begin
			done_reg <= busy_reg && !start && (left_reg == 9'h000);
			if (busy_reg && left_reg == 9'h000) begin
				count_reg <= sum_reg + {8'h00, level};
			end
		end
	end

	assign done = done_reg;
	assign count = count_reg;
endmodule // stc_accum

// ---- core/stc_top.sv ----
// Strobed register access is this design's own decision.
module stc_top #(
	parameter int unsigned CAL_SCALE = stc_pkg::CAL_SCALE
) (
	// clock and reset
	input  logic                    clk,
	input  logic                    nrst,
	// register port
	input  logic [stc_pkg::AW-1:0]  addr,
	input  logic [stc_pkg::DW-1:0]  wdata,
	input  logic                    wr_en,
	input  logic                    rd_en,
	output logic [stc_pkg::DW-1:0]  rdata,
	// sysref pin
	input  logic                    sysref,
	// delay word and interrupt
	output logic [stc_pkg::TW-1:0]  tad_out,
	output logic                    irq
);
	logic                   sync1_reg;
	logic                   sync2_reg;
	logic                   sync3_reg;
	logic                   edge_w;
	logic                   en_reg;
	logic                   en_prev_reg;
	logic                   start_w;
	logic [7:0]             cfg_reg;
	logic [stc_pkg::TW-1:0] tad_reg;
	logic [1:0]             ist_reg;
	logic [1:0]             imsk_reg;
	logic [stc_pkg::DW-1:0] rdata_reg;
	logic [stc_pkg::TW-1:0] tad_out_reg;
	logic                   irq_reg;
	stc_pkg::stc_state_t    state_reg;
	logic [1:0]             avg_lat_reg;
	logic [1:0]             acc_lat_reg;
	logic [31:0]            bound_reg;
	logic [31:0]            run_reg;
	logic [15:0]            per_reg;
	logic                   per_seen_reg;
	logic [8:0]             navg_reg;
	logic [16:0]            sum_reg;
	logic [7:0]             coarse_reg;
	logic                   first_reg;
	logic                   acc_start_reg;
	logic                   acc_done;
	logic [8:0]             acc_count;
	logic [stc_pkg::TW-1:0] res_reg;
	logic                   done_reg;
	logic                   done_ev_reg;
	logic                   fail_ev_reg;
	logic [24:0]            frac_wide;
	logic [8:0]             frac;
	logic                   per_bad;
	logic                   time_bad;
	logic                   wr_ist;

	//////////////////////////////////////////////////////////////////////////
	// sysref synchroniser and rising edge
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sync1_reg <= 1'b0;
			sync2_reg <= 1'b0;
			sync3_reg <= 1'b0;
		end else begin
			sync1_reg <= sysref;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
		end
	end

	assign edge_w = sync2_reg && !sync3_reg;

	//////////////////////////////////////////////////////////////////////////
	// software registers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			en_reg <= 1'b0;
			cfg_reg <= stc_pkg::CFG_RST;
			tad_reg <= '0;
			imsk_reg <= 2'h0;
		end else if (wr_en) begin
			case (addr)
				stc_pkg::ADDR_EN: en_reg <= wdata[0];
				stc_pkg::ADDR_CFG: cfg_reg <= {4'h0, wdata[3:0]};
				stc_pkg::ADDR_TAD: tad_reg <= wdata[stc_pkg::TW-1:0];
				stc_pkg::ADDR_IMSK: imsk_reg <= wdata[1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			en_prev_reg <= 1'b0;
		end else begin
			en_prev_reg <= en_reg;
		end
	end

	assign start_w = en_reg && !en_prev_reg;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rdata_reg <= '0;
		end else if (rd_en) begin
			case (addr)
				stc_pkg::ADDR_EN: rdata_reg <= {23'h000000, en_reg};
				stc_pkg::ADDR_CFG: rdata_reg <= {16'h0000, cfg_reg};
				stc_pkg::ADDR_RES: rdata_reg <= {6'h00, en_reg && done_reg, res_reg};
				stc_pkg::ADDR_TAD: rdata_reg <= {7'h00, tad_reg};
				stc_pkg::ADDR_IST: rdata_reg <= {22'h000000, ist_reg};
				stc_pkg::ADDR_IMSK: rdata_reg <= {22'h000000, imsk_reg};
				default: rdata_reg <= '0;
			endcase
		end else begin
			rdata_reg <= '0;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// calibration sequencer
	assign per_bad = per_seen_reg && (per_reg >= stc_pkg::per_max(acc_lat_reg));
	assign time_bad = run_reg >= bound_reg;

	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_reg <= stc_pkg::ST_IDLE;
			avg_lat_reg <= 2'h0;
			acc_lat_reg <= 2'h0;
			bound_reg <= '0;
			navg_reg <= 9'h000;
			sum_reg <= 17'h00000;
			acc_start_reg <= 1'b0;
		end else begin
			acc_start_reg <= 1'b0;
			if (!en_reg) begin
				state_reg <= stc_pkg::ST_IDLE;
			end else if (start_w) begin
				state_reg <= stc_pkg::ST_WAIT;
				avg_lat_reg <= cfg_reg[stc_pkg::AVG_LSB+:2];
				acc_lat_reg <= cfg_reg[stc_pkg::ACC_LSB+:2];
				bound_reg <= CAL_SCALE << stc_pkg::shift_of(cfg_reg[3:2], cfg_reg[1:0]);
				navg_reg <= 9'h000;
				sum_reg <= 17'h00000;
			end else begin
				case (state_reg)
					stc_pkg::ST_WAIT: begin
						if (per_bad || time_bad) begin
							state_reg <= stc_pkg::ST_FAIL;
						end else if (edge_w) begin
							acc_start_reg <= 1'b1;
							state_reg <= stc_pkg::ST_ACC;
						end
					end
					stc_pkg::ST_ACC: begin
						if (per_bad || time_bad) begin
							state_reg <= stc_pkg::ST_FAIL;
						end else if (acc_done) begin
							sum_reg <= sum_reg + {8'h00, acc_count};
							navg_reg <= navg_reg + 9'h001;
							if (navg_reg + 9'h001 == stc_pkg::len_of(avg_lat_reg)) begin
								state_reg <= stc_pkg::ST_FIN;
							end else begin
								state_reg <= stc_pkg::ST_WAIT;
							end
						end
					end
					stc_pkg::ST_FIN: state_reg <= stc_pkg::ST_DONE;
					default: ;
				endcase
			end
		end
	end

	// run length and sysref period counters
	always_ff @(posedge clk) begin
		if (!nrst) begin
			run_reg <= '0;
			per_reg <= 16'h0000;
			per_seen_reg <= 1'b0;
		end else if (start_w) begin
			run_reg <= '0;
			per_reg <= 16'h0000;
			per_seen_reg <= 1'b0;
		end else if (state_reg == stc_pkg::ST_WAIT || state_reg == stc_pkg::ST_ACC) begin
			run_reg <= run_reg + 32'h00000001;
			if (edge_w) begin
				per_reg <= 16'h0000;
				per_seen_reg <= 1'b1;
			end else if (per_reg != 16'hFFFF) begin
				per_reg <= per_reg + 16'h0001;
			end
		end
	end

	// coarse phase: cycles from start to the first sysref edge
	always_ff @(posedge clk) begin
		if (!nrst) begin
			coarse_reg <= 8'h00;
			first_reg <= 1'b0;
		end else if (start_w) begin
			first_reg <= 1'b0;
		end else if (state_reg == stc_pkg::ST_WAIT && edge_w && !first_reg) begin
			coarse_reg <= run_reg[7:0];
			first_reg <= 1'b1;
		end
	end

	stc_accum u_accum (
		.clk      (clk),
		.nrst     (nrst),
		.start    (acc_start_reg),
		.len_code (acc_lat_reg),
		.level    (sync2_reg),
		.done     (acc_done),
		.count    (acc_count)
	);

	//////////////////////////////////////////////////////////////////////////
	// result word and completion
	assign frac_wide = {sum_reg, 8'h00} >> stc_pkg::shift_of(avg_lat_reg, acc_lat_reg);
	assign frac = (frac_wide > 25'h00000FF) ? 9'h0FF : frac_wide[8:0];

	always_ff @(posedge clk) begin
		if (!nrst) begin
			res_reg <= '0;
			done_reg <= 1'b0;
			done_ev_reg <= 1'b0;
			fail_ev_reg <= 1'b0;
		end else begin
			done_ev_reg <= 1'b0;
			fail_ev_reg <= 1'b0;
			if (!en_reg || start_w) begin
				done_reg <= 1'b0;
			end else if (state_reg == stc_pkg::ST_FIN) begin
				res_reg[stc_pkg::INV_BIT] <= frac >= stc_pkg::FRAC_HALF;
				res_reg[stc_pkg::COARSE_LSB+:8] <= coarse_reg;
				res_reg[stc_pkg::FINE_LSB+:8] <= frac[7:0];
				done_reg <= 1'b1;
				done_ev_reg <= 1'b1;
			end else if ((state_reg == stc_pkg::ST_WAIT || state_reg == stc_pkg::ST_ACC)
					&& (per_bad || time_bad)) begin
				fail_ev_reg <= 1'b1;
			end
		end
	end

	// delay output: calibrated when enabled, manual otherwise
	always_ff @(posedge clk) begin
		if (!nrst) begin
			tad_out_reg <= '0;
		end else begin
			tad_out_reg <= en_reg ? res_reg : tad_reg;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// interrupt status, write one to clear, set wins
	assign wr_ist = wr_en && (addr == stc_pkg::ADDR_IST);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ist_reg <= 2'h0;
			irq_reg <= 1'b0;
		end else begin
			ist_reg <= (ist_reg & ~(wr_ist ? wdata[1:0] : 2'h0)) | {fail_ev_reg, done_ev_reg};
			irq_reg <= |(ist_reg & imsk_reg);
		end
	end

	assign rdata = rdata_reg;
	assign tad_out = tad_out_reg;
	assign irq = irq_reg;

	//////////////////////////////////////////////////////////////////////////
	// checks
	chk_cfg_reset: assert property (@(posedge clk) disable iff (!nrst)
		$past(!nrst) |-> cfg_reg == stc_pkg::CFG_RST)
		else $error("configuration not at reset value");

	chk_done_gated: assert property (@(posedge clk) disable iff (!nrst)
		rd_en && addr == stc_pkg::ADDR_RES && !(en_reg && done_reg) |=> !rdata[17])
		else $error("completion read high while not complete");

	chk_start_clears: assert property (@(posedge clk) disable iff (!nrst)
		start_w |=> !done_reg && state_reg == stc_pkg::ST_WAIT ##0 !done_reg [*2])
		else $error("start did not clear completion");

	chk_acc_len: assert property (@(posedge clk) disable iff (!nrst)
		acc_start_reg && acc_lat_reg == 2'h0 && en_reg |-> !acc_done [*5] ##1 acc_done)
		else $error("accumulation length wrong");

	chk_period_fail: assert property (@(posedge clk) disable iff (!nrst)
		en_reg && !start_w && state_reg == stc_pkg::ST_WAIT && per_bad
		|=> state_reg == stc_pkg::ST_FAIL ##1 !done_reg)
		else $error("long sysref period did not fail");

	chk_run_bound: assert property (@(posedge clk) disable iff (!nrst)
		en_reg && !start_w && time_bad && state_reg inside {stc_pkg::ST_WAIT, stc_pkg::ST_ACC}
		|=> state_reg == stc_pkg::ST_FAIL)
		else $error("run exceeded its bound");

	chk_manual_tad: assert property (@(posedge clk) disable iff (!nrst)
		!en_reg |=> tad_out == $past(tad_reg))
		else $error("manual delay not followed");

	chk_avg_count: assert property (@(posedge clk) disable iff (!nrst)
		state_reg == stc_pkg::ST_FIN |-> navg_reg == stc_pkg::len_of(avg_lat_reg))
		else $error("average count wrong");

	chk_latch_codes: assert property (@(posedge clk) disable iff (!nrst)
		start_w |=> avg_lat_reg == $past(cfg_reg[3:2]) && acc_lat_reg == $past(cfg_reg[1:0]))
		else $error("codes not latched at start");

	chk_done_word: assert property (@(posedge clk) disable iff (!nrst)
		en_reg && state_reg == stc_pkg::ST_FIN |=> done_reg
		&& res_reg[7:0] == $past(frac[7:0]) && res_reg[15:8] == $past(coarse_reg))
		else $error("result word not latched");

	chk_fail_status: assert property (@(posedge clk) disable iff (!nrst)
		fail_ev_reg |=> ist_reg[stc_pkg::IRQ_FAIL])
		else $error("failure not recorded in status");

	chk_fail_nodone: assert property (@(posedge clk) disable iff (!nrst)
		state_reg == stc_pkg::ST_FAIL |-> !done_reg)
		else $error("failed run reports completion");

	chk_auto_tad: assert property (@(posedge clk) disable iff (!nrst)
		en_reg |=> tad_out == $past(res_reg))
		else $error("delay output not the calibrated word");

	chk_irq_raise: assert property (@(posedge clk) disable iff (!nrst)
		(ist_reg & imsk_reg) != 2'h0 |=> irq)
		else $error("interrupt missing for unmasked status");

	chk_irq_drop: assert property (@(posedge clk) disable iff (!nrst)
		(ist_reg & imsk_reg) == 2'h0 |=> !irq)
		else $error("interrupt high without unmasked status");

	cov_done: cover property (@(posedge clk) disable iff (!nrst) $rose(done_reg));
	cov_fail: cover property (@(posedge clk) disable iff (!nrst) fail_ev_reg);
	cov_irq: cover property (@(posedge clk) disable iff (!nrst) $rose(irq_reg));
	cov_period_fail: cover property (@(posedge clk) disable iff (!nrst)
		state_reg == stc_pkg::ST_WAIT && per_bad);
	cov_time_fail: cover property (@(posedge clk) disable iff (!nrst)
		state_reg == stc_pkg::ST_WAIT && time_bad);
endmodule // stc_top

// ---- tb/stc_sysref_src.sv ----
module stc_sysref_src (
	// clock and control
	input  wire logic        clk,
	input  wire logic        run,
	input  wire logic [15:0] period,
	input  wire logic [15:0] high,
	// pin
	output logic             sysref
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] cnt;

	// periodic pulse; bench picks the period for each run
	always @(posedge clk) begin
		if (!run) begin
			cnt <= 16'h0000;
		end else if (cnt >= period - 16'h0001) begin
			cnt <= 16'h0000;
		end else begin
			cnt <= cnt + 16'h0001;
		end
	end

	// idle low between bursts
	assign sysref = run && (cnt < high);
endmodule // stc_sysref_src

// ---- tb/sysref_timing_calibration_bench.sv ----
module sysref_timing_calibration_bench;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int CS = 16;

	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [9:0]  addr = 10'h000;
	logic [23:0] wdata = 24'h000000;
	logic        wr_en = 1'b0;
	logic        rd_en = 1'b0;
	logic [23:0] rdata;
	logic        sysref;
	logic [16:0] tad_out;
	logic        irq;
	logic        run = 1'b0;
	logic [15:0] period = 16'h0028;
	int          n_fail = 0;
	int          checks = 0;

	always #12.5 clk = ~clk;

	stc_top #(.CAL_SCALE(CS)) DUT (
		.clk     (clk),
		.nrst    (nrst),
		.addr    (addr),
		.wdata   (wdata),
		.wr_en   (wr_en),
		.rd_en   (rd_en),
		.rdata   (rdata),
		.sysref  (sysref),
		.tad_out (tad_out),
		.irq     (irq)
	);

	stc_sysref_src src (
		.clk    (clk),
		.run    (run),
		.period (period),
		.high   (16'h0014),
		.sysref (sysref)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		if (n_fail == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [9:0] a, input logic [23:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	task automatic rd(input logic [9:0] a, output logic [23:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rdata;
	endtask

	// enable a run and count cycles until the interrupt rises
	task automatic run_cal(input logic [1:0] avg, input logic [1:0] acc, input bit poke,
		output int cyc);
		wr(stc_pkg::ADDR_EN, 24'h000000);
		wr(stc_pkg::ADDR_CFG, {20'h00000, avg, acc});
		wr(stc_pkg::ADDR_EN, 24'h000001);
		cyc = 2;
		if (poke) begin
			wr(stc_pkg::ADDR_CFG, 24'h00000F);
		end
		while (irq !== 1'b1 && cyc < 40000) begin
			@(posedge clk);
			#1 cyc++;
		end
		chk("run_end", {23'h0, irq}, 24'h000001);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		logic [23:0] d;
		rd(stc_pkg::ADDR_CFG, d);
		chk("cfg_reset", d, 24'h000005);
		rd(stc_pkg::ADDR_RES, d);
		chk("res_reset", d, 24'h000000);
		rd(10'h3FF, d);
		chk("unmapped", d, 24'h000000);
		rd(stc_pkg::ADDR_IMSK, d);
		chk("mask_reset", d, 24'h000000);
		rd(stc_pkg::ADDR_EN, d);
		chk("en_reset", d, 24'h000000);
		rd(stc_pkg::ADDR_IST, d);
		chk("ist_reset", d, 24'h000000);
		chk("tad_reset", {7'h00, tad_out}, 24'h000000);
		chk("irq_reset", {23'h0, irq}, 24'h000000);
	endtask

	task automatic t_config();
		logic [23:0] d;
		wr(stc_pkg::ADDR_CFG, 24'h0000FF);
		rd(stc_pkg::ADDR_CFG, d);
		chk("cfg_upper", d, 24'h00000F);
		wr(stc_pkg::ADDR_TAD, 24'h01ABCD);
		rd(stc_pkg::ADDR_TAD, d);
		chk("tad_read", d, 24'h01ABCD);
		chk("tad_manual", {7'h00, tad_out}, 24'h01ABCD);
	endtask

	task automatic t_sweep();
		logic [1:0]  avg_t [7] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0};
		logic [1:0]  acc_t [7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
		logic [23:0] d;
		int          cyc;
		int          prev;
		int          navg;
		int          alen;
		int          lo;
		prev = 0;
		wr(stc_pkg::ADDR_IMSK, 24'h000003);
		for (int i = 0; i < 7; i++) begin
			run_cal(avg_t[i], acc_t[i], 1'b0, cyc);
			navg = 4 << (2 * avg_t[i]);
			alen = 4 << (2 * acc_t[i]);
			lo = (navg - 1) * 40 > navg * alen ? (navg - 1) * 40 : navg * alen;
			chk("run_bound", {23'h0, cyc <= CS * (4 ** (avg_t[i] + acc_t[i] + 2))}, 24'h1);
			chk("run_length", {23'h0, cyc >= lo}, 24'h000001);
			if (i > 0 && i < 4) begin
				chk("avg_longer", {23'h0, cyc > prev}, 24'h000001);
			end
			prev = cyc;
			rd(stc_pkg::ADDR_RES, d);
			chk("done_flag", {23'h0, d[17]}, 24'h000001);
			chk("tad_auto", {7'h00, tad_out}, {7'h00, d[16:0]});
			if (i == 0) begin
				chk("invert", {23'h0, d[16]}, 24'h000001);
				chk("fine", {16'h0000, d[7:0]}, 24'h0000FF);
			end
			rd(stc_pkg::ADDR_IST, d);
			chk("ist_done", d, 24'h000001);
			wr(stc_pkg::ADDR_IST, 24'h000003);
			rd(stc_pkg::ADDR_IST, d);
			chk("irq_clear", {23'h0, irq}, 24'h000000);
		end
	endtask

	task automatic t_fail();
		logic [23:0] d;
		int          cyc;
		period <= 16'h00C8;
		wr(stc_pkg::ADDR_IMSK, 24'h000003);
		run_cal(2'h1, 2'h0, 1'b0, cyc);
		rd(stc_pkg::ADDR_RES, d);
		chk("fail_nodone", {23'h0, d[17]}, 24'h000000);
		rd(stc_pkg::ADDR_IST, d);
		chk("fail_status", d, 24'h000002);
		wr(stc_pkg::ADDR_IMSK, 24'h000001);
		rd(stc_pkg::ADDR_IST, d);
		chk("irq_masked", {23'h0, irq}, 24'h000000);
		wr(stc_pkg::ADDR_IMSK, 24'h000002);
		rd(stc_pkg::ADDR_IST, d);
		chk("irq_unmask", {23'h0, irq}, 24'h000001);
		wr(stc_pkg::ADDR_IST, 24'h000002);
		rd(stc_pkg::ADDR_IST, d);
		chk("irq_w1c", {23'h0, irq}, 24'h000000);
		run <= 1'b0;
		run_cal(2'h0, 2'h0, 1'b0, cyc);
		chk("time_early", {23'h0, cyc > CS * 16}, 24'h000001);
		chk("time_late", {23'h0, cyc <= CS * 16 + 8}, 24'h000001);
		rd(stc_pkg::ADDR_RES, d);
		chk("time_nodone", {23'h0, d[17]}, 24'h000000);
		rd(stc_pkg::ADDR_IST, d);
		chk("time_status", d, 24'h000002);
		wr(stc_pkg::ADDR_IST, 24'h000002);
		run <= 1'b1;
		period <= 16'h0028;
	endtask

	task automatic t_restart();
		logic [23:0] d;
		int          cyc;
		wr(stc_pkg::ADDR_IMSK, 24'h000001);
		run_cal(2'h0, 2'h0, 1'b1, cyc);
		chk("latched_codes", {23'h0, cyc <= CS * 16}, 24'h000001);
		wr(stc_pkg::ADDR_EN, 24'h000000);
		rd(stc_pkg::ADDR_RES, d);
		chk("done_off", {23'h0, d[17]}, 24'h000000);
		chk("tad_back", {7'h00, tad_out}, 24'h01ABCD);
		wr(stc_pkg::ADDR_IST, 24'h000003);
		wr(stc_pkg::ADDR_EN, 24'h000001);
		rd(stc_pkg::ADDR_RES, d);
		chk("done_restart", {23'h0, d[17]}, 24'h000000);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(25 * 60000);
		n_fail++;
		close_out();
	end

	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		run <= 1'b1;
		t_reset();
		t_config();
		t_sweep();
		t_fail();
		t_restart();
		close_out();
	end
endmodule // sysref_timing_calibration_bench
